// file: shared/dpmrc_defs.svh
`ifndef DPMRC_DEFS_SVH
`define DPMRC_DEFS_SVH
// Contract
// [R1] Full area, idle off, awake: whole panel driven with 262,144 colours.
// [R2] Partial area, idle off, awake: only selected rows driven, full colour depth.
// [R3] Full area, idle on, awake: whole panel reduced to eight colours.
// [R4] Partial area, idle on, awake: only selected rows, eight colours.
// [R5] Sleep halts converter, oscillator, panel drive; host interface and memory keep working.
// [R6] Powered modes change only by host commands; power-off never by command.
// [R7] Any reset: column window defaults to 0000h..013Fh.
// [R8] Any reset: row window defaults to 0000h..01DFh.
// [R9] Any reset: partial rows default to 0000h..01DFh.
// [R10] Any reset: pixel format defaults to eighteen bits per pixel.
// [R11] Any reset: tearing output disabled, mode vertical-blanking only.
// [R12] During any reset drive nothing: buses released, pwm and tearing low.
// [R13] Reset pin low under 5us ignored, over 9us resets.
// [R14] Short high glitches during a valid reset pulse do not end it.
// [R15] Factory settings loaded from non-volatile memory within 5 ms of release.
// [R16] Reset while awake blanks display within 120 ms; asleep stays blank.
// [R17] Host waits 5 ms before commands, 120 ms before sleep exit.
// [R18] Hardware reset overrides chip select; chip select may be tied active.
// [R19] Host holds reset low at least ten microseconds.
// [R20] Any reset: asleep, full area, display off, idle off, pixel overrides cleared.

// timing
`define DPMRC_CLK_MHZ 100
`define DPMRC_RST_REJECT_US 5
`define DPMRC_RST_REJECT_CYC (`DPMRC_RST_REJECT_US * `DPMRC_CLK_MHZ)
`define DPMRC_CYC_PER_MS (`DPMRC_CLK_MHZ * 1000)
`define DPMRC_NVM_LOAD_MS 5
`define DPMRC_NVM_LOAD_CYC (`DPMRC_NVM_LOAD_MS * `DPMRC_CYC_PER_MS)
`define DPMRC_BLANK_MS 120
`define DPMRC_BLANK_CYC (`DPMRC_BLANK_MS * `DPMRC_CYC_PER_MS)

// register offsets
`define DPMRC_OFF_CMD 8'h00
`define DPMRC_OFF_STATUS 8'h04
`define DPMRC_OFF_COL_WIN 8'h08
`define DPMRC_OFF_ROW_WIN 8'h0c
`define DPMRC_OFF_PART_WIN 8'h10
`define DPMRC_OFF_CFG 8'h14
`define DPMRC_OFF_FACTORY 8'h18

// reset values, window words are {end, start}
`define DPMRC_COL_WIN_RST 32'h013f_0000
`define DPMRC_ROW_WIN_RST 32'h01df_0000
`define DPMRC_PART_WIN_RST 32'h01df_0000
`define DPMRC_CFG_RST 32'h0000_0006
`define DPMRC_CFG_MASK 32'h0000_ff07
`define DPMRC_WIN_END_LSB 16
`define DPMRC_CMD_ARG_BIT 8
`define DPMRC_FULL_COLOR_BITS 5'h12
`define DPMRC_IDLE_COLOR_BITS 5'h03

// command codes
`define DPMRC_CMD_SW_RESET 8'h01
`define DPMRC_CMD_SLEEP_ENTER 8'h02
`define DPMRC_CMD_SLEEP_EXIT 8'h03
`define DPMRC_CMD_FULL_AREA_ON 8'h04
`define DPMRC_CMD_PARTIAL_ON 8'h05
`define DPMRC_CMD_IDLE_ON 8'h06
`define DPMRC_CMD_REDUCED_COLOR_OFF 8'h07
`define DPMRC_CMD_DISPLAY_OFF 8'h08
`define DPMRC_CMD_DISPLAY_ON 8'h09
`define DPMRC_CMD_ALL_PIX_OFF 8'h0a
`define DPMRC_CMD_ALL_PIX_ON 8'h0b
`define DPMRC_CMD_TE_OFF 8'h0c
`define DPMRC_CMD_TE_ON 8'h0d
`define DPMRC_CMD_PIX_NORMAL 8'h0e

`endif

// file: shared/dpmrc_pkg.sv
package dpmrc_pkg;

  typedef enum logic [1:0] {SEQ_HOLD, SEQ_START, SEQ_WAIT, SEQ_RUN} dpmrc_seq_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic [9:0] cnt;
  } dpmrc_filt_type;

  typedef struct packed {
    logic [23:0] cnt;
    logic done;
  } dpmrc_tmr_type;

  typedef struct packed {
    dpmrc_seq_type seq;
    logic was_awake;
    logic sleep;
    logic partial;
    logic idle;
    logic disp_on;
    logic all_on;
    logic all_off;
    logic te_en;
    logic te_mode;
    logic [31:0] col_win;
    logic [31:0] row_win;
    logic [31:0] part_win;
    logic [31:0] cfg;
    logic [31:0] factory;
    logic cs_s1;
    logic cs_s2;
    logic awready;
    logic wready;
    logic arready;
    logic aw_held;
    logic w_held;
    logic bvalid;
    logic rvalid;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic dcdc_en;
    logic osc_en;
    logic panel_en;
    logic drive_partial;
    logic blank;
    logic db_oe;
    logic sdo_oe;
    logic hs_oe;
    logic pwm;
    logic te;
    logic [4:0] color_bits;
    logic [15:0] row_first;
    logic [15:0] row_last;
  } dpmrc_core_type;

endpackage

// file: core/dpmrc_rst_filter.sv
`timescale 1ns/1ps
`include "dpmrc_defs.svh"
module dpmrc_rst_filter import dpmrc_pkg::*; #(
  parameter int unsigned STABLE_CYC = `DPMRC_RST_REJECT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // raw pin and filtered level
  input wire logic pin_n,
  output logic released
);
  localparam logic [9:0] LAST = 10'(STABLE_CYC - 1);
  dpmrc_filt_type s, n;

  // the level only flips after STABLE_CYC identical samples, so both low spikes
  // and high glitches inside a reset pulse are swallowed
  always_comb begin
    n = s;
    n.s1 = pin_n;
    n.s2 = s.s1;
    if (s.s2 == s.level) begin
      n.cnt = '0;
    end else if (s.cnt == LAST) begin
      n.level = s.s2; // [R13] [R14]
      n.cnt = '0;
    end else begin
      n.cnt = s.cnt + 10'd1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{s1: 1'b1, s2: 1'b1, level: 1'b1, cnt: 10'h000};
    end else begin
      s <= n;
    end
  end

  assign released = s.level;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_SHORT_LOW_IGNORED: assert property (s.level && !s.s2 && s.cnt < LAST |=> s.level) // [R13]
    else $error("short low pulse changed reset level");
  AST_LONG_LOW_RESETS: assert property (s.level && !s.s2 && s.cnt == LAST |=> !s.level) // [R13]
    else $error("long low pulse did not reset");
  AST_HIGH_GLITCH_HELD: assert property (!s.level && s.s2 && s.cnt < LAST |=> !s.level) // [R14]
    else $error("high glitch ended reset");
endmodule // dpmrc_rst_filter

// file: core/dpmrc_delay_timer.sv
`timescale 1ns/1ps
module dpmrc_delay_timer import dpmrc_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  input wire logic [23:0] limit,
  output logic done
);
  dpmrc_tmr_type s, n;

  always_comb begin
    n = s;
    if (start) begin
      n.cnt = limit;
      n.done = 1'b0;
    end else if (!s.done) begin
      n.cnt = s.cnt - 24'd1;
      if (s.cnt <= 24'd1) begin
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{cnt: 24'h00_0000, done: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign done = s.done;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_START_CLEARS: assert property (start |=> !s.done) // [R15]
    else $error("timer done right after start");
  AST_EXPIRES: assert property (!start && !s.done && s.cnt == 24'd1 |=> s.done) // [R15] [R16]
    else $error("timer missed its expiry");
endmodule // dpmrc_delay_timer

// file: core/dpmrc_top.sv
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "dpmrc_defs.svh"
module dpmrc_top import dpmrc_pkg::*; #(
  parameter int unsigned NVM_LOAD_CYC = `DPMRC_NVM_LOAD_CYC,
  parameter int unsigned BLANK_CYC = `DPMRC_BLANK_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // host pins
  input wire logic hw_reset_n_pin,
  input wire logic chip_select_n_pin,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // factory word from non-volatile memory
  input wire logic [31:0] nvm_factory_data,
  // display timing and output requests
  input wire logic vblank_in,
  input wire logic hblank_in,
  input wire logic pwm_level_in,
  input wire logic db_drive_req,
  input wire logic sdo_drive_req,
  input wire logic hs_drive_req,
  // pad controls
  output logic parallel_data_bus_oe,
  output logic serial_data_out_oe,
  output logic hs_data_lane_oe,
  output logic backlight_pwm_out,
  output logic tearing_sync_out,
  // power and panel drive
  output logic dcdc_en,
  output logic osc_en,
  output logic panel_drive_en,
  output logic [4:0] color_depth_bits,
  output logic partial_drive,
  output logic [15:0] panel_row_first,
  output logic [15:0] panel_row_last,
  output logic panel_blank
);
  localparam logic [23:0] LOAD_LIM = 24'(NVM_LOAD_CYC);
  localparam logic [23:0] BLANK_LIM = 24'(BLANK_CYC);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam dpmrc_core_type CORE_RST = '{
    seq: SEQ_START, sleep: 1'b1, col_win: `DPMRC_COL_WIN_RST, row_win: `DPMRC_ROW_WIN_RST,
    part_win: `DPMRC_PART_WIN_RST, cfg: `DPMRC_CFG_RST, cs_s1: 1'b1, cs_s2: 1'b1,
    awready: 1'b1, wready: 1'b1, arready: 1'b1, blank: 1'b1, color_bits: `DPMRC_FULL_COLOR_BITS,
    row_last: 16'h01df, default: '0};

  dpmrc_core_type s, n;
  logic pin_released;
  logic load_done;
  logic blank_done;
  logic cmd_ok;
  logic cmd_fire;
  logic [7:0] cmd_code;
  logic quiet;
  logic awake;

  function automatic logic [31:0] dpmrc_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  dpmrc_rst_filter u_rst_filter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_n(hw_reset_n_pin),
    .released(pin_released)
  );

  // load and blank timers both start at the one-cycle start state
  dpmrc_delay_timer u_load_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(s.seq == SEQ_START),
    .limit(LOAD_LIM),
    .done(load_done)
  );

  // asleep at reset means nothing to blank, so the wait collapses to one cycle
  dpmrc_delay_timer u_blank_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(s.seq == SEQ_START),
    .limit(s.was_awake ? BLANK_LIM : 24'd1),
    .done(blank_done)
  );

  assign cmd_ok = (s.seq == SEQ_RUN) && !s.cs_s2;
  assign cmd_code = s.wdata[7:0];
  assign cmd_fire = s.aw_held && s.w_held && !s.bvalid && cmd_ok && (s.awaddr == `DPMRC_OFF_CMD);

  always_comb begin
    n = s;
    quiet = 1'b1;
    awake = 1'b0;
    n.cs_s1 = chip_select_n_pin;
    n.cs_s2 = s.cs_s1;

    // write channel: address and data taken in either order
    if (s.awready && s_axi_awvalid) begin
      n.aw_held = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = cmd_ok ? RESP_OKAY : RESP_SLVERR; // [R18]
      if (cmd_ok) begin
        unique case (s.awaddr)
          `DPMRC_OFF_CMD: begin
            unique case (cmd_code)
              `DPMRC_CMD_SW_RESET: begin
                n.was_awake = !s.sleep;
                n.seq = SEQ_START;
              end
              `DPMRC_CMD_SLEEP_ENTER: n.sleep = 1'b1; // [R6]
              `DPMRC_CMD_SLEEP_EXIT: begin
                // refused while a reset blanking is still running [R17]
                if (blank_done) begin
                  n.sleep = 1'b0;
                end else begin
                  n.bresp = RESP_SLVERR;
                end
              end
              `DPMRC_CMD_FULL_AREA_ON: n.partial = 1'b0;
              `DPMRC_CMD_PARTIAL_ON: n.partial = 1'b1;
              `DPMRC_CMD_IDLE_ON: n.idle = 1'b1;
              `DPMRC_CMD_REDUCED_COLOR_OFF: n.idle = 1'b0;
              `DPMRC_CMD_DISPLAY_OFF: n.disp_on = 1'b0;
              `DPMRC_CMD_DISPLAY_ON: n.disp_on = 1'b1;
              `DPMRC_CMD_ALL_PIX_OFF: begin
                n.all_off = 1'b1;
                n.all_on = 1'b0;
              end
              `DPMRC_CMD_ALL_PIX_ON: begin
                n.all_on = 1'b1;
                n.all_off = 1'b0;
              end
              `DPMRC_CMD_PIX_NORMAL: begin
                n.all_on = 1'b0;
                n.all_off = 1'b0;
              end
              `DPMRC_CMD_TE_OFF: n.te_en = 1'b0;
              `DPMRC_CMD_TE_ON: begin
                n.te_en = 1'b1;
                n.te_mode = s.wdata[`DPMRC_CMD_ARG_BIT];
              end
              default: n.bresp = RESP_SLVERR;
            endcase
          end
          `DPMRC_OFF_COL_WIN: n.col_win = dpmrc_merge(s.col_win, s.wdata, s.wstrb);
          `DPMRC_OFF_ROW_WIN: n.row_win = dpmrc_merge(s.row_win, s.wdata, s.wstrb);
          `DPMRC_OFF_PART_WIN: n.part_win = dpmrc_merge(s.part_win, s.wdata, s.wstrb);
          `DPMRC_OFF_CFG: n.cfg = dpmrc_merge(s.cfg, s.wdata, s.wstrb) & `DPMRC_CFG_MASK;
          default: n.bresp = RESP_SLVERR;
        endcase
      end
    end

    // read channel, registers stay readable in sleep and in reset
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        `DPMRC_OFF_CMD: n.rdata = 32'h0000_0000;
        `DPMRC_OFF_STATUS: n.rdata = {21'h00_0000, blank_done, load_done, s.seq == SEQ_RUN, s.te_mode,
                                      s.te_en, s.all_off, s.all_on, s.disp_on, s.idle, s.partial, s.sleep};
        `DPMRC_OFF_COL_WIN: n.rdata = s.col_win;
        `DPMRC_OFF_ROW_WIN: n.rdata = s.row_win;
        `DPMRC_OFF_PART_WIN: n.rdata = s.part_win;
        `DPMRC_OFF_CFG: n.rdata = s.cfg;
        `DPMRC_OFF_FACTORY: n.rdata = s.factory;
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end

    // reset sequence
    unique case (s.seq)
      SEQ_HOLD: begin
        if (pin_released) begin
          n.seq = SEQ_START;
        end
      end
      SEQ_START: n.seq = SEQ_WAIT;
      SEQ_WAIT: begin
        if (load_done) begin
          n.seq = SEQ_RUN;
          n.factory = nvm_factory_data; // [R15]
        end
      end
      SEQ_RUN: begin
      end
    endcase
    if (!pin_released) begin
      if (s.seq == SEQ_RUN) begin
        n.was_awake = !s.sleep; // [R16]
      end
      n.seq = SEQ_HOLD; // [R18]
    end

    // defaults held through the whole reset and its start cycle
    if (n.seq == SEQ_HOLD || n.seq == SEQ_START) begin
      n.sleep = 1'b1; // [R20]
      n.partial = 1'b0;
      n.idle = 1'b0;
      n.disp_on = 1'b0;
      n.all_on = 1'b0;
      n.all_off = 1'b0;
      n.col_win = `DPMRC_COL_WIN_RST; // [R7]
      n.row_win = `DPMRC_ROW_WIN_RST; // [R8]
      n.part_win = `DPMRC_PART_WIN_RST; // [R9]
      n.cfg = `DPMRC_CFG_RST; // [R10]
      n.te_en = 1'b0; // [R11]
      n.te_mode = 1'b0;
    end

    n.awready = !n.aw_held;
    n.wready = !n.w_held;
    n.arready = !n.rvalid;

    // pad and panel controls follow the next state so they react without lag
    quiet = n.seq != SEQ_RUN;
    awake = !quiet && !n.sleep;
    n.dcdc_en = awake; // [R5]
    n.osc_en = awake;
    n.panel_en = awake;
    n.color_bits = n.idle ? `DPMRC_IDLE_COLOR_BITS : `DPMRC_FULL_COLOR_BITS; // [R1] [R3]
    n.drive_partial = n.partial; // [R2] [R4]
    n.row_first = n.partial ? n.part_win[15:0] : 16'h0000;
    n.row_last = n.partial ? n.part_win[`DPMRC_WIN_END_LSB +: 16] : 16'h01df;
    n.blank = quiet || !blank_done || n.sleep || !n.disp_on || n.all_off; // [R16]
    n.db_oe = !quiet && db_drive_req; // [R12]
    n.sdo_oe = !quiet && sdo_drive_req;
    n.hs_oe = !quiet && hs_drive_req;
    n.pwm = !quiet && pwm_level_in;
    n.te = !quiet && n.te_en && (vblank_in || (n.te_mode && hblank_in));
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= CORE_RST;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign parallel_data_bus_oe = s.db_oe;
  assign serial_data_out_oe = s.sdo_oe;
  assign hs_data_lane_oe = s.hs_oe;
  assign backlight_pwm_out = s.pwm;
  assign tearing_sync_out = s.te;
  assign dcdc_en = s.dcdc_en;
  assign osc_en = s.osc_en;
  assign panel_drive_en = s.panel_en;
  assign color_depth_bits = s.color_bits;
  assign partial_drive = s.drive_partial;
  assign panel_row_first = s.row_first;
  assign panel_row_last = s.row_last;
  assign panel_blank = s.blank;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence exit_early_s;
    cmd_fire && cmd_code == `DPMRC_CMD_SLEEP_EXIT && !blank_done;
  endsequence
  sequence reset_begin_s;
    !pin_released ##1 s.seq == SEQ_HOLD;
  endsequence

  AST_FULL_COLOR: assert property (!s.idle |-> s.color_bits == 5'd18) // [R1] [R2]
    else $error("full colour depth missing");
  AST_IDLE_COLOR: assert property (s.idle |-> s.color_bits == 5'd3 && s.row_first == (s.partial ? // [R3] [R4]
    s.part_win[15:0] : 16'h0000)) else $error("idle colours or rows wrong");
  AST_PARTIAL_ROWS: assert property (s.drive_partial |-> s.row_last == s.part_win[31:16]) // [R2] [R4]
    else $error("partial rows not driven");
  AST_SLEEP_HALTS: assert property (s.sleep |-> !s.dcdc_en && !s.osc_en && !s.panel_en) // [R5]
    else $error("sleep left power blocks on");
  AST_MODE_BY_CMD: assert property ($changed(s.partial) && $past(s.seq) == SEQ_RUN && s.seq == SEQ_RUN // [R6]
    |-> $past(cmd_fire)) else $error("mode changed without command");
  AST_WINDOW_DEFAULTS: assert property (s.seq == SEQ_START |-> s.col_win == 32'h013f_0000 // [R7] [R8] [R9]
    && s.row_win == 32'h01df_0000 && s.part_win == 32'h01df_0000) else $error("window defaults wrong");
  AST_FORMAT_DEFAULTS: assert property (s.seq == SEQ_START |-> s.cfg[2:0] == 3'h6 && !s.te_en // [R10] [R11]
    && !s.te_mode) else $error("format or tearing defaults wrong");
  AST_QUIET_PINS: assert property (s.seq != SEQ_RUN |-> !s.db_oe && !s.sdo_oe && !s.hs_oe // [R12]
    && !s.pwm && !s.te) else $error("pins driven during reset");
  AST_LOAD_THEN_RUN: assert property (s.seq == SEQ_WAIT && load_done && pin_released |=> s.seq == SEQ_RUN // [R15]
    && s.factory == $past(nvm_factory_data)) else $error("load completion not taken");
  AST_EXIT_REFUSED: assert property (exit_early_s |=> s.sleep && s.bresp == 2'b10) // [R16] [R17]
    else $error("sleep exit during blanking");
  AST_RESET_WINS: assert property (reset_begin_s |-> s.sleep && !s.disp_on && s.blank) // [R18] [R20]
    else $error("reset did not override");
endmodule // dpmrc_top

// file: verification/dpmrc_host_model.sv
`timescale 1ns/1ps
module dpmrc_host_model (
  // clock
  input wire logic core_clk,
  // reset pin toward the device
  output logic hw_reset_n_pin
);
  initial hw_reset_n_pin = 1'b1;
  // level changes just after an edge and holds for whole cycles
  task automatic drive(input logic lvl, input int cyc);
    hw_reset_n_pin <= lvl;
    repeat (cyc) @(posedge core_clk);
  endtask
endmodule // dpmrc_host_model

// file: verification/testbench.sv
`timescale 1ns/1ps
`include "dpmrc_defs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  logic core_clk, sys_rst, chip_select_n_pin;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, nvm_factory_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic vblank_in, hblank_in, pwm_level_in, db_drive_req, sdo_drive_req, hs_drive_req;
  logic parallel_data_bus_oe, serial_data_out_oe, hs_data_lane_oe, backlight_pwm_out, tearing_sync_out;
  logic dcdc_en, osc_en, panel_drive_en, partial_drive, panel_blank, hw_reset_n_pin;
  logic [4:0] color_depth_bits;
  logic [15:0] panel_row_first, panel_row_last;
  int fails = 0;
  int num_checks = 0;

  dpmrc_top #(.NVM_LOAD_CYC(20), .BLANK_CYC(40)) dut (.core_clk, .sys_rst, .hw_reset_n_pin,
    .chip_select_n_pin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .nvm_factory_data, .vblank_in, .hblank_in, .pwm_level_in, .db_drive_req, .sdo_drive_req,
    .hs_drive_req, .parallel_data_bus_oe, .serial_data_out_oe, .hs_data_lane_oe, .backlight_pwm_out,
    .tearing_sync_out, .dcdc_en, .osc_en, .panel_drive_en, .color_depth_bits, .partial_drive,
    .panel_row_first, .panel_row_last, .panel_blank);
  dpmrc_host_model host (.core_clk, .hw_reset_n_pin);

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // entered just after an edge; valid drops only at the edge that takes it
  // ready stays high between calls so it is never lowered and raised in one step
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        return;
      end
    end
    fails++;
    test_done();
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        return;
      end
    end
    fails++;
    test_done();
  endtask

  task automatic cmd(input logic [7:0] c);
    logic [1:0] r;
    axw(`DPMRC_OFF_CMD, {24'h00_0000, c}, r);
    `CHK("cmd resp", 2'b00, r)
  endtask

  // polls status bit b (run or blank done); host sends nothing else until then
  task automatic wait_bit(input int b);
    logic [31:0] d;
    logic [1:0] r;
    for (int n = 0; n < 400; n++) begin
      axr(`DPMRC_OFF_STATUS, d, r);
      if (d[b] === 1'b1) return;
    end
    fails++;
    test_done();
  endtask

  task automatic t_defaults(input string nm);
    logic [31:0] d;
    logic [1:0] r;
    axr(`DPMRC_OFF_COL_WIN, d, r);
    `CHK("col_win", 32'h013f_0000, d)
    axr(`DPMRC_OFF_ROW_WIN, d, r);
    `CHK("row_win", 32'h01df_0000, d)
    axr(`DPMRC_OFF_PART_WIN, d, r);
    `CHK("part_win", 32'h01df_0000, d)
    axr(`DPMRC_OFF_CFG, d, r);
    `CHK("cfg", 32'h0000_0006, d)
    axr(`DPMRC_OFF_STATUS, d, r);
    `CHK("status", 10'h301, d[9:0])
    `CHK("tearing", 1'b0, tearing_sync_out)
    `CHK("color", 5'h12, color_depth_bits)
    axr(`DPMRC_OFF_FACTORY, d, r);
    `CHK("factory", 32'h5a5a_c3c3, d)
    $display("test defaults %s done", nm);
  endtask

  task automatic t_modes();
    logic [7:0] code [5] = '{`DPMRC_CMD_SLEEP_EXIT, `DPMRC_CMD_PARTIAL_ON, `DPMRC_CMD_IDLE_ON,
      `DPMRC_CMD_FULL_AREA_ON, `DPMRC_CMD_REDUCED_COLOR_OFF};
    logic [4:0] col [5] = '{5'h12, 5'h12, 5'h03, 5'h03, 5'h12};
    logic part [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [31:0] d;
    logic [1:0] r;
    axw(`DPMRC_OFF_PART_WIN, 32'h0100_0020, r);
    for (int i = 0; i < 5; i++) begin
      cmd(code[i]);
      @(posedge core_clk);
      `CHK("dcdc", 1'b1, dcdc_en)
      `CHK("color", col[i], color_depth_bits)
      `CHK("partial", part[i], partial_drive)
      `CHK("row_first", part[i] ? 16'h0020 : 16'h0000, panel_row_first)
      `CHK("row_last", part[i] ? 16'h0100 : 16'h01df, panel_row_last)
    end
    cmd(`DPMRC_CMD_SLEEP_ENTER);
    @(posedge core_clk);
    `CHK("sleep power", 3'b000, {dcdc_en, osc_en, panel_drive_en})
    axr(`DPMRC_OFF_PART_WIN, d, r);
    `CHK("retained", 32'h0100_0020, d)
    $display("test modes done");
  endtask

  task automatic t_refuse();
    logic [31:0] d;
    logic [1:0] r;
    chip_select_n_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    axw(`DPMRC_OFF_CFG, 32'h0000_1205, r);
    `CHK("cs high resp", 2'b10, r)
    chip_select_n_pin <= 1'b0;
    repeat (3) @(posedge core_clk);
    axw(8'h1c, 32'h0000_0001, r);
    `CHK("unmapped wr", 2'b10, r)
    axr(8'h1c, d, r);
    `CHK("unmapped rd", 34'h2_0000_0000, {r, d})
    axw(`DPMRC_OFF_CFG, 32'hffff_1205, r);
    axr(`DPMRC_OFF_CFG, d, r);
    `CHK("cfg masked", 32'h0000_1205, d)
    cmd(`DPMRC_CMD_SW_RESET);
    wait_bit(8);
    t_defaults("sw_reset");
    $display("test refuse done");
  endtask

  task automatic t_pin();
    logic [31:0] d;
    logic [1:0] r;
    cmd(`DPMRC_CMD_SLEEP_EXIT);
    cmd(`DPMRC_CMD_TE_ON);
    cmd(`DPMRC_CMD_DISPLAY_ON);
    cmd(`DPMRC_CMD_ALL_PIX_ON);
    axw(`DPMRC_OFF_CFG, 32'h0000_1205, r);
    @(posedge core_clk);
    `CHK("tearing on", 1'b1, tearing_sync_out)
    `CHK("unblank", 1'b0, panel_blank)
    host.drive(1'b0, 400);
    host.drive(1'b1, 20);
    axr(`DPMRC_OFF_CFG, d, r);
    `CHK("short pulse", 32'h0000_1205, d)
    host.drive(1'b0, 1000);
    host.drive(1'b1, 100);
    host.drive(1'b0, 300);
    `CHK("pads", 6'h00, {parallel_data_bus_oe, serial_data_out_oe, hs_data_lane_oe,
      backlight_pwm_out, tearing_sync_out, dcdc_en})
    `CHK("blank in reset", 1'b1, panel_blank)
    axw(`DPMRC_OFF_CFG, 32'h0000_0001, r);
    `CHK("reset wr", 2'b10, r)
    host.drive(1'b0, 300);
    host.drive(1'b1, 1);
    wait_bit(8);
    axw(`DPMRC_OFF_CMD, {24'h00_0000, `DPMRC_CMD_SLEEP_EXIT}, r);
    `CHK("early exit", 2'b10, r)
    t_defaults("pin_reset");
    wait_bit(10);
    cmd(`DPMRC_CMD_SLEEP_EXIT);
    cmd(`DPMRC_CMD_DISPLAY_ON);
    cmd(`DPMRC_CMD_ALL_PIX_OFF);
    cmd(`DPMRC_CMD_TE_OFF);
    axr(`DPMRC_OFF_STATUS, d, r);
    `CHK("status", 8'h28, d[7:0])
    `CHK("all off blank", 1'b1, panel_blank)
    cmd(`DPMRC_CMD_PIX_NORMAL);
    @(posedge core_clk);
    `CHK("unblank", 1'b0, panel_blank)
    cmd(`DPMRC_CMD_DISPLAY_OFF);
    @(posedge core_clk);
    `CHK("display off", 1'b1, panel_blank)
    $display("test pin done");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    sys_rst = 1'b1;
    chip_select_n_pin = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    nvm_factory_data = 32'h5a5a_c3c3;
    {vblank_in, hblank_in, pwm_level_in} = 3'b101;
    {db_drive_req, sdo_drive_req, hs_drive_req} = 3'b111;
    repeat (5) @(posedge core_clk);
    `CHK("pads in reset", 5'h00, {parallel_data_bus_oe, serial_data_out_oe, hs_data_lane_oe,
      backlight_pwm_out, tearing_sync_out})
    sys_rst <= 1'b0;
    wait_bit(8);
    t_defaults("power_on");
    t_modes();
    t_refuse();
    t_pin();
    test_done();
  end
endmodule // testbench
